/* ctm_pkg.sv */
// constants and types shared by the compact timer core
package ctm_pkg;

    // instances and bus
    localparam int          NUM_TMR     = 2;
    localparam int          ADDR_W      = 8;
    localparam int          REG_LSB     = 2;
    localparam int          INST_LSB    = 5;

    // word index of each register inside one instance
    localparam logic [2:0]  REG_CTRL0   = 3'h0;
    localparam logic [2:0]  REG_CTRL1   = 3'h1;
    localparam logic [2:0]  REG_CNT_LO  = 3'h2;
    localparam logic [2:0]  REG_CNT_HI  = 3'h3;
    localparam logic [2:0]  REG_CMPA_LO = 3'h4;
    localparam logic [2:0]  REG_CMPA_HI = 3'h5;

    // timer_control_0 fields
    localparam int          C0_PAUSE    = 7;
    localparam int          C0_CK_LSB   = 4;
    localparam int          C0_ON       = 3;
    localparam int          C0_RP_LSB   = 0;

    // timer_control_1 fields
    localparam int          C1_MODE_LSB = 6;
    localparam int          C1_IO_LSB   = 4;
    localparam int          C1_INIT     = 3;
    localparam int          C1_POL      = 2;
    localparam int          C1_DPX      = 1;
    localparam int          C1_CCLR     = 0;

    // reset values
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [9:0]  CNT_RST     = 10'h000;

    // mode_select codes
    localparam logic [1:0]  MODE_CMP    = 2'h0;
    localparam logic [1:0]  MODE_PWM    = 2'h2;
    localparam logic [1:0]  MODE_TMR    = 2'h3;

    // clock_select codes
    localparam logic [2:0]  CK_SYS4     = 3'h0;
    localparam logic [2:0]  CK_SYS      = 3'h1;
    localparam logic [2:0]  CK_H16      = 3'h2;
    localparam logic [2:0]  CK_H64      = 3'h3;
    localparam logic [2:0]  CK_SUB0     = 3'h4;
    localparam logic [2:0]  CK_SUB1     = 3'h5;
    localparam logic [2:0]  CK_EXT_R    = 3'h6;
    localparam logic [2:0]  CK_EXT_F    = 3'h7;

    // pin_function_select codes
    localparam logic [1:0]  IO_NONE     = 2'h0;
    localparam logic [1:0]  IO_LOW      = 2'h1;
    localparam logic [1:0]  IO_HIGH     = 2'h2;
    localparam logic [1:0]  IO_TOGGLE   = 2'h3;

    // prescaler and sub clock timing
    localparam int          PRE_W       = 6;
    localparam logic [5:0]  PRE_MASK4   = 6'h03;
    localparam logic [5:0]  PRE_MASK16  = 6'h0F;
    localparam logic [5:0]  PRE_MASK64  = 6'h3F;
    localparam int          REF_HZ      = 200_000_000;
    localparam int          SUB_HZ      = 32_768;
    localparam int          SUB_DIV     = REF_HZ / SUB_HZ;
    localparam int          SUB_W       = 16;

    // one timer instance
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] cnt;
        logic [9:0] cmpa;
        logic [7:0] buffer;
        logic       ext_q;
        logic       level;
        logic       pin;
        logic       pin_n;
        logic       oe;
        logic       match_a;
        logic       match_p;
    } tmr_t;

    // apb answer
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } apb_rsp_t;

    // whole core state
    typedef struct packed {
        apb_rsp_t                 rsp;
        logic [PRE_W-1:0]         pre;
        logic [SUB_W-1:0]         sub;
        logic                     sub_tick;
        tmr_t [NUM_TMR-1:0]       tmr;
    } state_t;

endpackage

/* compact_timer_counter_core.sv */
// two compact 10-bit timers with byte-buffered register pairs behind an apb slave
// Summary of operation
// R1 - low bytes pass only through a shared byte buffer, moved on high-byte access
// R2 - writing compare a low byte loads only the shared buffer; counter low byte writes are ignored
// R3 - writing high byte stores it and copies buffer into the low byte
// R4 - reading high byte returns it and captures the live low byte into buffer
// R5 - reading low byte returns the buffer, not the live value
// R6 - software writes low then high, reads high then low
// R7 - 10-bit up-counter advances on selected internal or external clock
// R8 - period comparator checks its 3 bits against counter bits 9 to 7
// R9 - comparator a checks all ten counter bits
// R10 - software cannot load counter; only counter-on rising clears it (overflow and the selected match also clear it, see R11)
// R11 - counter clears on overflow or selected match; match request raised
// R12 - counter pair read only; compare a pair read write, 10 bits each
// R13 - low register holds bits 7..0, high register bits 9..8 at bottom
// R14 - upper six bits of counter high byte read as zero
// R15 - compare output, timer/counter and pwm modes are supported
// R16 - two control registers hold the full operating setup
// R17 - timer pins connect only when pin-shared selection chooses timer
// R18 - mode 00 compare, 10 pwm, 11 timer/counter, 01 undefined
// R19 - clock select picks sys/4, sys, h/16, h/64, sub, pin rise or fall
// R20 - period match at code times 128 clocks, code zero means 1024
// R21 - counter-on rising clears counter, falling stops and keeps value
// R22 - each timer instance has its own counter, buffer and registers
`timescale 1ns/1ps

module compact_timer_counter_core #(
    parameter int SUB_DIV = ctm_pkg::SUB_DIV
) (
    // clock and reset
    input  wire logic                        REF_CLK,
    input  wire logic                        NRST,
    // apb slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [ctm_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic                             PREADY,
    output logic [31:0]                      PRDATA,
    output logic                             PSLVERR,
    // pin-shared selection
    input  wire logic [ctm_pkg::NUM_TMR-1:0] EXT_CLK_SEL,
    input  wire logic [ctm_pkg::NUM_TMR-1:0] OUT_PIN_SEL,
    // timer pins
    input  wire logic [ctm_pkg::NUM_TMR-1:0] EXT_CLK,
    output logic      [ctm_pkg::NUM_TMR-1:0] TMR_OUT,
    output logic      [ctm_pkg::NUM_TMR-1:0] TMR_OUT_N,
    output logic      [ctm_pkg::NUM_TMR-1:0] TMR_OUT_OE,
    // match requests
    output logic      [ctm_pkg::NUM_TMR-1:0] MATCH_A,
    output logic      [ctm_pkg::NUM_TMR-1:0] MATCH_P
);

    localparam logic [ctm_pkg::SUB_W-1:0] SUB_LAST = ctm_pkg::SUB_W'(SUB_DIV - 1);

    ctm_pkg::state_t q;
    ctm_pkg::state_t d;

    // counter clock enable for one clock_select code
    function automatic logic clk_tick(
        input logic [2:0]                ck,
        input logic [ctm_pkg::PRE_W-1:0] pre,
        input logic                      sub_tick,
        input logic                      rise,
        input logic                      fall
    );
        logic t;
        t = 1'b0;
        case (ck)                                                       // R19
            ctm_pkg::CK_SYS4:  t = (pre & ctm_pkg::PRE_MASK4) == ctm_pkg::PRE_MASK4;
            ctm_pkg::CK_SYS:   t = 1'b1;
            ctm_pkg::CK_H16:   t = (pre & ctm_pkg::PRE_MASK16) == ctm_pkg::PRE_MASK16;
            ctm_pkg::CK_H64:   t = pre == ctm_pkg::PRE_MASK64;
            ctm_pkg::CK_SUB0:  t = sub_tick;
            ctm_pkg::CK_SUB1:  t = sub_tick;
            ctm_pkg::CK_EXT_R: t = rise;
            ctm_pkg::CK_EXT_F: t = fall;
            default:           t = 1'b0;
        endcase
        return t;
    endfunction

    // pwm drive level for the given pin function and counter value
    function automatic logic pwm_level(
        input ctm_pkg::tmr_t t,
        input logic [9:0]    cnt
    );
        logic [9:0] duty;
        logic       act;
        logic [1:0] io;
        logic       lvl;
        duty = t.ctrl1[ctm_pkg::C1_DPX] ? {t.ctrl0[ctm_pkg::C0_RP_LSB +: 3], 7'h00} : t.cmpa;
        act  = cnt < duty;
        io   = t.ctrl1[ctm_pkg::C1_IO_LSB +: 2];
        lvl  = ~t.ctrl1[ctm_pkg::C1_INIT];
        case (io)
            2'h0:    lvl = ~t.ctrl1[ctm_pkg::C1_INIT];
            2'h1:    lvl = t.ctrl1[ctm_pkg::C1_INIT];
            2'h2:    lvl = act ? t.ctrl1[ctm_pkg::C1_INIT] : ~t.ctrl1[ctm_pkg::C1_INIT];
            default: lvl = ~t.ctrl1[ctm_pkg::C1_INIT];
        endcase
        return lvl;
    endfunction

    logic                   setup_acc;
    logic                   done_acc;
    logic [2:0]             reg_idx;
    logic [2:0]             inst_idx;
    logic                   mapped;

    always_comb begin
        setup_acc = PSEL && PENABLE && !q.rsp.ready;
        done_acc  = PSEL && PENABLE && q.rsp.ready;
        reg_idx   = PADDR[ctm_pkg::REG_LSB +: 3];
        inst_idx  = PADDR[ctm_pkg::INST_LSB +: 3];
        mapped    = (32'(inst_idx) < ctm_pkg::NUM_TMR) && (reg_idx <= ctm_pkg::REG_CMPA_HI);
    end

    always_comb begin
        logic [9:0] nxt;
        logic       tick;
        logic       rise;
        logic       fall;
        logic       run;
        logic       hit_a;
        logic       hit_p;
        logic       clr;
        logic [1:0] mode;
        logic [1:0] io;
        logic       sel;
        logic [7:0] wb;
        nxt   = 10'h000;
        tick  = 1'b0;
        rise  = 1'b0;
        fall  = 1'b0;
        run   = 1'b0;
        hit_a = 1'b0;
        hit_p = 1'b0;
        clr   = 1'b0;
        mode  = 2'h0;
        io    = 2'h0;
        sel   = 1'b0;
        wb    = PWDATA[7:0];
        d     = q;

        // shared prescaler and sub clock divider
        d.pre      = q.pre + 1'b1;
        d.sub_tick = q.sub == SUB_LAST;
        d.sub      = d.sub_tick ? '0 : q.sub + 1'b1;

        // apb answer: one wait state, data and error latched in it
        d.rsp.ready = setup_acc;
        if (!setup_acc) begin
            d.rsp.err   = 1'b0;
            d.rsp.rdata = 32'h0000_0000;
        end else begin
            d.rsp.err   = !mapped;
            d.rsp.rdata = 32'h0000_0000;
        end

        for (int i = 0; i < ctm_pkg::NUM_TMR; i++) begin                 // R22
            sel  = mapped && (32'(inst_idx) == i);
            mode = q.tmr[i].ctrl1[ctm_pkg::C1_MODE_LSB +: 2];
            io   = q.tmr[i].ctrl1[ctm_pkg::C1_IO_LSB +: 2];

            // external clock pin, usable only when selected for the timer
            d.tmr[i].ext_q = EXT_CLK[i] & EXT_CLK_SEL[i];                // R17
            rise = d.tmr[i].ext_q & ~q.tmr[i].ext_q;
            fall = ~d.tmr[i].ext_q & q.tmr[i].ext_q;
            tick = clk_tick(q.tmr[i].ctrl0[ctm_pkg::C0_CK_LSB +: 3], q.pre, q.sub_tick, rise, fall);

            // counter stops and keeps its value when off or paused
            run = q.tmr[i].ctrl0[ctm_pkg::C0_ON] && !q.tmr[i].ctrl0[ctm_pkg::C0_PAUSE] && tick; // R7 R21
            nxt = q.tmr[i].cnt + 10'h001;
            hit_a = run && (nxt == q.tmr[i].cmpa);                           // R9
            hit_p = run && (nxt[9:7] == q.tmr[i].ctrl0[ctm_pkg::C0_RP_LSB +: 3])     // R8 R20
                        && (q.tmr[i].cnt[9:7] != q.tmr[i].ctrl0[ctm_pkg::C0_RP_LSB +: 3]);
            clr   = q.tmr[i].ctrl1[ctm_pkg::C1_CCLR] ? hit_a : hit_p;
            d.tmr[i].match_a = hit_a;                                         // R11
            d.tmr[i].match_p = hit_p;                                         // R11
            if (run) begin
                d.tmr[i].cnt = clr ? ctm_pkg::CNT_RST : nxt;                  // R11
            end

            // compare match output mode acts on comparator a
            if (mode == ctm_pkg::MODE_CMP && hit_a) begin                     // R15 R18
                case (io)
                    ctm_pkg::IO_LOW:    d.tmr[i].level = 1'b0;
                    ctm_pkg::IO_HIGH:   d.tmr[i].level = 1'b1;
                    ctm_pkg::IO_TOGGLE: d.tmr[i].level = ~q.tmr[i].level;
                    default:            d.tmr[i].level = q.tmr[i].level;
                endcase
            end

            // register reads with buffer side effects
            if (setup_acc && sel && !PWRITE) begin
                case (reg_idx)
                    ctm_pkg::REG_CTRL0: d.rsp.rdata = {24'h00_0000, q.tmr[i].ctrl0};
                    ctm_pkg::REG_CTRL1: d.rsp.rdata = {24'h00_0000, q.tmr[i].ctrl1};
                    ctm_pkg::REG_CNT_LO, ctm_pkg::REG_CMPA_LO: begin
                        d.rsp.rdata = {24'h00_0000, q.tmr[i].buffer};            // R5 R1
                    end
                    ctm_pkg::REG_CNT_HI: begin
                        d.rsp.rdata     = {24'h00_0000, 6'h00, q.tmr[i].cnt[9:8]};  // R4 R13 R14
                        d.tmr[i].buffer = q.tmr[i].cnt[7:0];                     // R4
                    end
                    ctm_pkg::REG_CMPA_HI: begin
                        d.rsp.rdata     = {24'h00_0000, 6'h00, q.tmr[i].cmpa[9:8]}; // R4 R12
                        d.tmr[i].buffer = q.tmr[i].cmpa[7:0];                    // R4
                    end
                    default: d.rsp.rdata = 32'h0000_0000;
                endcase
            end

            // register writes take effect at the completing edge
            if (done_acc && sel && PWRITE) begin
                case (reg_idx)
                    ctm_pkg::REG_CTRL0: begin                                     // R16
                        d.tmr[i].ctrl0 = wb;
                        if (wb[ctm_pkg::C0_ON] && !q.tmr[i].ctrl0[ctm_pkg::C0_ON]) begin
                            d.tmr[i].cnt   = ctm_pkg::CNT_RST;                    // R10 R21
                            d.tmr[i].level = q.tmr[i].ctrl1[ctm_pkg::C1_INIT];
                        end
                    end
                    ctm_pkg::REG_CTRL1: d.tmr[i].ctrl1 = wb;                      // R16
                    ctm_pkg::REG_CMPA_LO: d.tmr[i].buffer = wb;                   // R2 R1
                    ctm_pkg::REG_CMPA_HI: d.tmr[i].cmpa = {wb[1:0], q.tmr[i].buffer}; // R3 R12
                    default: d.tmr[i].buffer = q.tmr[i].buffer;                   // R10 R12
                endcase
            end

            // pin drive from the next state
            if (d.tmr[i].ctrl1[ctm_pkg::C1_MODE_LSB +: 2] == ctm_pkg::MODE_PWM) begin // R15 R18
                d.tmr[i].pin = pwm_level(d.tmr[i], d.tmr[i].cnt) ^ d.tmr[i].ctrl1[ctm_pkg::C1_POL];
            end else begin
                d.tmr[i].pin = d.tmr[i].level ^ d.tmr[i].ctrl1[ctm_pkg::C1_POL];
            end
            d.tmr[i].pin_n = ~d.tmr[i].pin;
            d.tmr[i].oe    = OUT_PIN_SEL[i]
                             && (d.tmr[i].ctrl1[ctm_pkg::C1_MODE_LSB +: 2] != ctm_pkg::MODE_TMR); // R17 R18
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        PREADY  = q.rsp.ready;
        PRDATA  = q.rsp.rdata;
        PSLVERR = q.rsp.err;
        for (int i = 0; i < ctm_pkg::NUM_TMR; i++) begin
            TMR_OUT[i]    = q.tmr[i].pin;
            TMR_OUT_N[i]  = q.tmr[i].pin_n;
            TMR_OUT_OE[i] = q.tmr[i].oe;
            MATCH_A[i]    = q.tmr[i].match_a;
            MATCH_P[i]    = q.tmr[i].match_p;
        end
    end

endmodule // compact_timer_counter_core

/* compact_timer_counter_core_asserts.sv */
// port-level assertions for the compact timer core
`timescale 1ns/1ps

module compact_timer_counter_core_asserts #(
    parameter int SUB_DIV = ctm_pkg::SUB_DIV
) (
    // clock, reset and apb
    input wire logic        REF_CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    // pins and match pulses
    input wire logic [1:0]  EXT_CLK_SEL,
    input wire logic [1:0]  OUT_PIN_SEL,
    input wire logic [1:0]  EXT_CLK,
    input wire logic [1:0]  TMR_OUT,
    input wire logic [1:0]  TMR_OUT_N,
    input wire logic [1:0]  TMR_OUT_OE,
    input wire logic [1:0]  MATCH_A,
    input wire logic [1:0]  MATCH_P
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_wait; PSEL && PENABLE && !PREADY; endsequence
    sequence s_rd(logic [2:0] r); PREADY && !PWRITE && PADDR[4:2] == r; endsequence

    property p_ready; s_setup ##1 s_wait |=> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready missing after wait cycle");
    property p_once; PREADY |=> !PREADY; endproperty
    a_once: assert property (p_once) else $error("ready held too long");
    property p_unmap; PREADY && (PADDR[7:5] > 3'h1 || PADDR[4:2] > 3'h5) |-> PSLVERR && PRDATA == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_map; PREADY && PADDR[7:5] < 3'h2 && PADDR[4:2] < 3'h6 |-> !PSLVERR; endproperty
    a_map: assert property (p_map) else $error("mapped access refused");
    property p_byte; PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000; endproperty
    a_byte: assert property (p_byte) else $error("read data wider than a byte");
    property p_cnt_hi; s_rd(ctm_pkg::REG_CNT_HI) |-> PRDATA[7:2] == 6'h00; endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("counter high byte upper bits set");
    property p_cmp_hi; s_rd(ctm_pkg::REG_CMPA_HI) |-> PRDATA[7:2] == 6'h00; endproperty
    a_cmp_hi: assert property (p_cmp_hi) else $error("compare high byte upper bits set");
    property p_oe; |TMR_OUT_OE |-> (TMR_OUT_OE & ~$past(OUT_PIN_SEL)) == 2'h0; endproperty
    a_oe: assert property (p_oe) else $error("pin driven without pin selection");
    property p_pin_n; $past(NRST) |-> TMR_OUT_N == ~TMR_OUT; endproperty
    a_pin_n: assert property (p_pin_n) else $error("inverted pin not inverse");
endmodule // compact_timer_counter_core_asserts

/* apb_host_model.sv */
// apb master model standing in for the processor core
`timescale 1ns/1ps

module apb_host_model (
    // clock
    input  wire logic        clk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one transfer: setup, then access held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask
endmodule // apb_host_model

/* compact_timer_counter_core_test.sv */
// self-checking bench for the compact timer core
`timescale 1ns/1ps

module compact_timer_counter_core_test;
    localparam int SUB_DIV_SIM = 4;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  ext_clk = 2'h0;
    logic [1:0]  tmr_out, tmr_out_n, tmr_out_oe, match_a, match_p;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          n;
    int          divs[8] = '{4, 1, 16, 64, SUB_DIV_SIM, SUB_DIV_SIM, 6, 6};
    logic [1:0]  ext_sel = 2'h3;
    logic [7:0]  pwm_cfg[4] = '{8'h98, 8'h9c, 8'ha8, 8'haa};
    logic        pwm_lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #2.5 ref_clk = ~ref_clk;
    always begin
        repeat (3) @(posedge ref_clk);
        ext_clk <= ~ext_clk;
    end

    compact_timer_counter_core #(.SUB_DIV(SUB_DIV_SIM)) i_dut (
        .REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .EXT_CLK_SEL(ext_sel),
        .OUT_PIN_SEL(2'h1), .EXT_CLK(ext_clk), .TMR_OUT(tmr_out), .TMR_OUT_N(tmr_out_n),
        .TMR_OUT_OE(tmr_out_oe), .MATCH_A(match_a), .MATCH_P(match_p));
    apb_host_model i_host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic wr(input int t, input logic [2:0] r, input logic [7:0] d);
        i_host.xfer(1'b1, {t[2:0], r, 2'h0}, {24'h00_0000, d}, q, e);
    endtask
    task automatic rd(input int t, input logic [2:0] r);
        i_host.xfer(1'b0, {t[2:0], r, 2'h0}, 32'h0000_0000, q, e);
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // cycles between two pulses of match a or match p of timer 0
    task automatic gap(input bit use_p, output int c);
        for (int i = 0; i < 2; i++) begin
            c = 0;
            do begin
                @(posedge ref_clk);
                c++;
            end while ((use_p ? match_p[0] : match_a[0]) !== 1'b1 && c < 6000);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int r = 0; r < 6; r++) begin
            rd(0, r[2:0]);
            chk("reset value", q, 32'h0000_0000);
        end
        i_host.xfer(1'b0, 8'h18, 32'h0000_0000, q, e);
        chk("unmapped offset", e, 32'h0000_0001);
        i_host.xfer(1'b1, 8'h40, 32'h0000_00ff, q, e);
        chk("unmapped timer", e, 32'h0000_0001);
        // low byte alone reaches only the buffer
        wr(0, ctm_pkg::REG_CMPA_LO, 8'h5a);
        rd(0, ctm_pkg::REG_CMPA_HI);
        rd(0, ctm_pkg::REG_CMPA_LO);
        chk("compare low unchanged", q, 32'h0000_0000);
        wr(0, ctm_pkg::REG_CMPA_LO, 8'ha5);
        wr(0, ctm_pkg::REG_CMPA_HI, 8'hff);
        wr(1, ctm_pkg::REG_CMPA_LO, 8'h11);
        rd(0, ctm_pkg::REG_CMPA_HI);
        chk("compare high", q, 32'h0000_0003);
        rd(0, ctm_pkg::REG_CMPA_LO);
        chk("compare low", q, 32'h0000_00a5);
        rd(0, ctm_pkg::REG_CNT_HI);
        rd(0, ctm_pkg::REG_CMPA_LO);
        chk("shared buffer", q, 32'h0000_0000);
        rd(1, ctm_pkg::REG_CMPA_HI);
        rd(1, ctm_pkg::REG_CMPA_LO);
        chk("other timer compare", q, 32'h0000_0000);
        // run, stop, then restart paused: counter cleared, not writable
        wr(0, ctm_pkg::REG_CTRL1, 8'hc0);
        wr(0, ctm_pkg::REG_CTRL0, 8'h18);
        wr(0, ctm_pkg::REG_CTRL0, 8'h10);
        wr(0, ctm_pkg::REG_CTRL0, 8'h98);
        wr(0, ctm_pkg::REG_CNT_LO, 8'hff);
        wr(0, ctm_pkg::REG_CNT_HI, 8'h03);
        rd(0, ctm_pkg::REG_CNT_HI);
        chk("counter high", q, 32'h0000_0000);
        rd(0, ctm_pkg::REG_CNT_LO);
        chk("counter low", q, 32'h0000_0000);
        // pin enable per mode
        for (int m = 1; m < 4; m++) begin
            wr(0, ctm_pkg::REG_CTRL1, {m[1:0], 6'h00});
            repeat (2) @(posedge ref_clk);
            chk("pin enable", tmr_out_oe, {1'b0, m[1:0] != ctm_pkg::MODE_TMR});
        end
        // pwm levels: fixed active, polarity, duty from compare a or period
        for (int j = 0; j < 4; j++) begin
            wr(0, ctm_pkg::REG_CTRL1, pwm_cfg[j]);
            @(posedge ref_clk);
            chk("pwm level", tmr_out[0], pwm_lvl[j]);
        end
        // compare a over all ten bits clears the counter
        wr(0, ctm_pkg::REG_CMPA_LO, 8'h05);
        wr(0, ctm_pkg::REG_CMPA_HI, 8'h01);
        wr(0, ctm_pkg::REG_CTRL1, 8'h31);
        wr(0, ctm_pkg::REG_CTRL0, 8'h18);
        gap(1'b0, n);
        chk("compare period", n, 32'h0000_0105);
        wr(0, ctm_pkg::REG_CTRL1, 8'h21);
        gap(1'b0, n);
        chk("compare set level", tmr_out[0], 1'b1);
        wr(0, ctm_pkg::REG_CTRL1, 8'h11);
        gap(1'b0, n);
        chk("compare clear level", tmr_out[0], 1'b0);
        wr(0, ctm_pkg::REG_CMPA_LO, 8'h03);
        wr(0, ctm_pkg::REG_CMPA_HI, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(0, ctm_pkg::REG_CTRL0, {1'b0, k[2:0], 4'h8});
            gap(1'b0, n);
            chk("clock select", n, 3 * divs[k]);
        end
        // pin clock ignored while the pin is not given to the timer
        ext_sel <= 2'h2;
        repeat (2) @(posedge ref_clk);
        rd(0, ctm_pkg::REG_CNT_HI);
        rd(0, ctm_pkg::REG_CNT_LO);
        n = q;
        rd(0, ctm_pkg::REG_CNT_HI);
        rd(0, ctm_pkg::REG_CNT_LO);
        chk("gated pin clock", q, n);
        ext_sel <= 2'h3;
        // period comparator on the top three counter bits
        wr(0, ctm_pkg::REG_CTRL1, 8'hc0);
        for (int p = 0; p < 8; p++) begin
            wr(0, ctm_pkg::REG_CTRL0, {5'h03, p[2:0]});
            gap(1'b1, n);
            chk("period", n, (p == 0) ? 1024 : p * 128);
        end
        print_verdict();
    end
endmodule // compact_timer_counter_core_test

bind compact_timer_counter_core compact_timer_counter_core_asserts #(.SUB_DIV(SUB_DIV)) i_asserts (
    .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EXT_CLK_SEL(EXT_CLK_SEL),
    .OUT_PIN_SEL(OUT_PIN_SEL), .EXT_CLK(EXT_CLK), .TMR_OUT(TMR_OUT), .TMR_OUT_N(TMR_OUT_N),
    .TMR_OUT_OE(TMR_OUT_OE), .MATCH_A(MATCH_A), .MATCH_P(MATCH_P));
